// file: hdl/rcq_core.sv
/*
  run command qualifier: scans terminal inputs, gates run commands on local/remote and
  drive mode, maps sub-minimum frequency references; registers over AXI4-Lite.
  assumes all inputs synchronous to aclk and one write and one read under way at a time.
*/
// Operation
// - below minimum: option 0 runs at reference, option 1 coasts to stop
// - option 2 runs at minimum frequency; option 3 zero speed in flux vector only
// - one scan setting serves forward/reverse and multi-function inputs alike
// - scan setting 0 takes two samples of each input every 2 ms
// - scan setting 1, default, takes two samples of each input every 5 ms
// - remote option 0 ignores run present at switch; needs fresh run assertion
// - remote option 1 honours a run present at switch straight away
// - non-drive option 0 ignores run outside drive mode until reissued; 1 runs
// - non-drive option 1 is invalid when run source selection is zero
`include "rcq_map.svh"

module rcq_core #(
    parameter int MF_W     = 8,
    parameter int FAST_CYC = `RCQ_FAST_CYC,
    parameter int SLOW_CYC = `RCQ_SLOW_CYC
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              terminal_fwd,
    input  wire logic              terminal_rev,
    input  wire logic [MF_W-1:0]   multi_in,
    input  wire logic              key_fwd,
    input  wire logic              key_rev,
    input  wire logic              remote_mode,
    input  wire logic              drive_mode,
    input  wire logic [15:0]       freq_ref,
    output logic [MF_W-1:0]        multi_q,
    output rcq_pkg::rcq_drive_s    drive_cmd
);
    import rcq_pkg::*;

    rcq_cfg_s        cfg;
    logic [31:0]     ctrl_q;
    logic [15:0]     minf_q;
    logic [MF_W+1:0] qual;
    logic            scan_tick;
    logic            q_fwd;
    logic            q_rev;
    logic            remote_prev_q;
    logic            remote_rise;
    logic            block_q;
    logic            block_now;
    logic            ndblk_q;
    logic            nd_ok;
    logic            src_fwd;
    logic            src_rev;
    logic            src_run;
    logic            term_run;
    logic            allowed;
    logic            below;
    logic            coast_d;
    logic [15:0]     freq_d;
    logic            aw_got_q;
    logic            w_got_q;
    logic [7:0]      awaddr_q;
    logic [31:0]     wdata_q;
    logic [3:0]      wstrb_q;
    logic            do_write;
    logic [31:0]     stat;

    assign cfg = rcq_cfg_s'(ctrl_q[`RCQ_FLUX_BIT:`RCQ_SUBMIN_LSB]);

    // one qualifier, one scan setting for every terminal input
    rcq_qualify #(
        .W        (MF_W + 2),
        .FAST_CYC (FAST_CYC),
        .SLOW_CYC (SLOW_CYC)
    ) u_qualify (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .slow_sel  (cfg.input_scan_rate_sel),
        .raw       ({multi_in, terminal_rev, terminal_fwd}),
        .level_q   (qual),
        .scan_tick (scan_tick)
    );

    assign q_fwd    = qual[0];
    assign q_rev    = qual[1];
    assign multi_q  = qual[MF_W+1:2];
    assign term_run = q_fwd | q_rev;

    // run command gating
    assign remote_rise = remote_mode & ~remote_prev_q;
    assign block_now   = block_q | (remote_rise & ~cfg.remote_switch_run_sel & term_run);
    assign nd_ok       = cfg.non_drive_run_sel & (cfg.run_source_sel != 2'b00);
    assign src_fwd     = remote_mode ? q_fwd : key_fwd;
    assign src_rev     = remote_mode ? q_rev : key_rev;
    assign src_run     = src_fwd | src_rev;
    // both directions at once is treated as stop
    assign allowed     = src_run & ~(src_fwd & src_rev) & ~(remote_mode & block_now)
                         & ~ndblk_q & (drive_mode | nd_ok);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remote_prev_q <= 1'b0;
        end else begin
            remote_prev_q <= remote_mode;
        end
    end

    // set beats release: a run held across the switch stays blocked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            block_q <= 1'b0;
        end else if (remote_rise && !cfg.remote_switch_run_sel && term_run) begin
            block_q <= 1'b1;
        end else if (!term_run) begin
            block_q <= 1'b0;
        end
    end

    // held until the run command is released, so it must be reissued in drive mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ndblk_q <= 1'b0;
        end else if (!drive_mode && src_run && !nd_ok) begin
            ndblk_q <= 1'b1;
        end else if (!src_run) begin
            ndblk_q <= 1'b0;
        end
    end

    // sub-minimum reference handling; zero speed without flux vector falls back to option 0
    assign below = (freq_ref < minf_q);

    always_comb begin
        coast_d = 1'b0;
        freq_d  = freq_ref;
        if (below) begin
            case (cfg.sub_minimum_action_sel)
                RCQ_SUB_RUN_REF: freq_d = freq_ref;
                RCQ_SUB_COAST: begin
                    coast_d = 1'b1;
                    freq_d  = 16'h0000;
                end
                RCQ_SUB_RUN_MIN: freq_d = minf_q;
                RCQ_SUB_ZERO: freq_d = cfg.flux_vector_mode ? 16'h0000 : freq_ref;
                default: freq_d = freq_ref;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_cmd <= '0;
        end else begin
            drive_cmd.run_fwd    <= allowed & src_fwd & ~coast_d;
            drive_cmd.run_rev    <= allowed & src_rev & ~coast_d;
            drive_cmd.coast_stop <= coast_d;
            drive_cmd.freq_cmd   <= freq_d;
        end
    end

    // axi4-lite write: address and data taken in either order, response after both
    assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got_q & ~s_axi_bvalid;
    assign do_write      = aw_got_q & w_got_q & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_got_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_got_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `RCQ_CTRL_RST;
            minf_q <= `RCQ_MINF_RST;
        end else if (do_write) begin
            if ({awaddr_q[7:2], 2'b00} == `RCQ_CTRL_OFS) begin
                if (wstrb_q[0]) begin
                    ctrl_q <= {24'h00_0000, wdata_q[7:0]};
                end
            end else if ({awaddr_q[7:2], 2'b00} == `RCQ_MINF_OFS) begin
                if (wstrb_q[0]) begin
                    minf_q[7:0] <= wdata_q[7:0];
                end
                if (wstrb_q[1]) begin
                    minf_q[15:8] <= wdata_q[15:8];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RCQ_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if ({awaddr_q[7:2], 2'b00} == `RCQ_CTRL_OFS
                || {awaddr_q[7:2], 2'b00} == `RCQ_MINF_OFS) begin
                s_axi_bresp <= `RCQ_RESP_OKAY;
            end else begin
                s_axi_bresp <= `RCQ_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // axi4-lite read; status is a live snapshot taken at the address handshake
    assign s_axi_arready = ~s_axi_rvalid;
    assign stat = 32'({multi_q, 8'h00, below, drive_cmd.coast_stop, drive_cmd.run_rev,
                       drive_cmd.run_fwd, ndblk_q, block_q, q_rev, q_fwd});

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RCQ_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RCQ_RESP_OKAY;
            if ({s_axi_araddr[7:2], 2'b00} == `RCQ_CTRL_OFS) begin
                s_axi_rdata <= ctrl_q;
            end else if ({s_axi_araddr[7:2], 2'b00} == `RCQ_MINF_OFS) begin
                s_axi_rdata <= {16'h0000, minf_q};
            end else if ({s_axi_araddr[7:2], 2'b00} == `RCQ_STAT_OFS) begin
                s_axi_rdata <= stat;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `RCQ_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // helper: cycles since the last scan
    logic [31:0] gap_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || scan_tick) begin
            gap_q <= 32'h0000_0000;
        end else begin
            gap_q <= gap_q + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sub_pass_a: assert property (
        below && cfg.sub_minimum_action_sel == RCQ_SUB_RUN_REF
        |=> drive_cmd.freq_cmd == $past(freq_ref) && !drive_cmd.coast_stop)
        else $error("option 0 did not pass the reference");

    sub_coast_a: assert property (
        below && cfg.sub_minimum_action_sel == RCQ_SUB_COAST
        |=> drive_cmd.coast_stop && !drive_cmd.run_fwd && !drive_cmd.run_rev)
        else $error("option 1 did not coast");

    sub_min_a: assert property (
        below && cfg.sub_minimum_action_sel == RCQ_SUB_RUN_MIN
        |=> drive_cmd.freq_cmd == $past(minf_q))
        else $error("option 2 did not run at minimum");

    sub_zero_a: assert property (
        below && cfg.sub_minimum_action_sel == RCQ_SUB_ZERO
        |=> drive_cmd.freq_cmd == ($past(cfg.flux_vector_mode) ? 16'h0000 : $past(freq_ref)))
        else $error("option 3 zero speed mishandled");

    scan_same_a: assert property (
        (multi_q != $past(multi_q)) || (q_fwd != $past(q_fwd)) |-> $past(scan_tick))
        else $error("input groups scanned apart");

    scan_fast_a: assert property (
        !cfg.input_scan_rate_sel && !$past(cfg.input_scan_rate_sel) |-> gap_q < 32'(FAST_CYC))
        else $error("fast scan period exceeded");

    scan_slow_a: assert property (
        cfg.input_scan_rate_sel |-> gap_q < 32'(SLOW_CYC))
        else $error("slow scan period exceeded");

    rem_block_a: assert property (
        remote_rise && !cfg.remote_switch_run_sel && term_run
        |=> !drive_cmd.run_fwd && !drive_cmd.run_rev)
        else $error("run held across remote switch was honoured");

    rem_pass_a: assert property (
        remote_rise && cfg.remote_switch_run_sel && q_fwd && !q_rev && !ndblk_q && !block_q
        && drive_mode && !coast_d |=> drive_cmd.run_fwd)
        else $error("run at remote switch not honoured");

    nd_ignore_a: assert property (
        !drive_mode && !nd_ok |=> !drive_cmd.run_fwd && !drive_cmd.run_rev)
        else $error("run honoured outside drive mode");

    nd_invalid_a: assert property (
        !drive_mode && cfg.run_source_sel == 2'b00 |=> !drive_cmd.run_fwd && !drive_cmd.run_rev)
        else $error("non-drive run honoured with run source zero");

endmodule // rcq_core

// file: hdl/rcq_map.svh
/*
  register offsets, field positions, reset values and scan timing of the run command qualifier.
  assumes inclusion by bare name from rcq_pkg and the design modules.
*/
`ifndef RCQ_MAP_SVH
`define RCQ_MAP_SVH

`define RCQ_CTRL_OFS      8'h00
`define RCQ_MINF_OFS      8'h04
`define RCQ_STAT_OFS      8'h08

`define RCQ_SUBMIN_LSB    0
`define RCQ_SCAN_BIT      2
`define RCQ_REMSW_BIT     3
`define RCQ_NDRV_BIT      4
`define RCQ_SRC_LSB       5
`define RCQ_FLUX_BIT      7
`define RCQ_MF_LSB        16

`define RCQ_CTRL_RST      32'h0000_0024
`define RCQ_MINF_RST      16'h0000

`define RCQ_CLK_MHZ       20
`define RCQ_WIN_FAST_MS   2
`define RCQ_WIN_SLOW_MS   5
`define RCQ_SCANS_PER_WIN 2
`define RCQ_FAST_CYC      (`RCQ_WIN_FAST_MS * 1000 * `RCQ_CLK_MHZ / `RCQ_SCANS_PER_WIN)
`define RCQ_SLOW_CYC      (`RCQ_WIN_SLOW_MS * 1000 * `RCQ_CLK_MHZ / `RCQ_SCANS_PER_WIN)

`define RCQ_RESP_OKAY     2'b00
`define RCQ_RESP_SLVERR   2'b10

`endif

// file: hdl/rcq_pkg.sv
/*
  types shared by the run command qualifier modules.
  assumes rcq_map.svh on the include path.
*/
`include "rcq_map.svh"

package rcq_pkg;

    typedef enum logic [1:0] {
        RCQ_SUB_RUN_REF,
        RCQ_SUB_COAST,
        RCQ_SUB_RUN_MIN,
        RCQ_SUB_ZERO
    } rcq_submin_e;

    typedef struct packed {
        logic        flux_vector_mode;
        logic [1:0]  run_source_sel;
        logic        non_drive_run_sel;
        logic        remote_switch_run_sel;
        logic        input_scan_rate_sel;
        rcq_submin_e sub_minimum_action_sel;
    } rcq_cfg_s;

    typedef struct packed {
        logic        run_fwd;
        logic        run_rev;
        logic        coast_stop;
        logic [15:0] freq_cmd;
    } rcq_drive_s;

endpackage : rcq_pkg

// file: hdl/rcq_qualify.sv
/*
  scan-rate sampler and two-scan agreement filter for a group of control inputs.
  assumes inputs synchronous to aclk and a scan rate select held by software.
*/
`include "rcq_map.svh"

module rcq_qualify #(
    parameter int W        = 4,
    parameter int FAST_CYC = `RCQ_FAST_CYC,
    parameter int SLOW_CYC = `RCQ_SLOW_CYC
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         slow_sel,
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] level_q,
    output logic              scan_tick
);
    import rcq_pkg::*;

    logic [31:0]  cnt_q;
    logic [31:0]  limit;
    logic [W-1:0] samp_q;

    // one scan period, both groups share it
    assign limit     = slow_sel ? 32'(SLOW_CYC - 1) : 32'(FAST_CYC - 1);
    // >= so a rate change mid-period never strands the counter
    assign scan_tick = (cnt_q >= limit);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 32'h0000_0000;
        end else if (scan_tick) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                samp_q[i]  <= 1'b0;
                level_q[i] <= 1'b0;
            end else if (scan_tick) begin
                samp_q[i] <= raw[i];
                if (raw[i] == samp_q[i] && raw[i] != level_q[i]) begin
                    level_q[i] <= raw[i];
                end
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // judged per bit: one input may qualify while another disagrees at the same tick
    two_scan_a: assert property (
        scan_tick |=> ((level_q ^ $past(level_q)) & ($past(raw) ^ $past(samp_q))) == '0)
        else $error("qualified level moved on a single disagreeing scan");

    tick_only_a: assert property (
        !scan_tick |=> level_q == $past(level_q))
        else $error("qualified level moved between scans");

endmodule // rcq_qualify

// file: dv/rcq_contact_model.sv
/*
  far side of rcq_core: run terminals and multi-function contacts, with optional bounce.
  assumes the bench sets the wanted levels and the bounce length right after a clock edge.
*/
module rcq_contact_model (
    input  wire logic       aclk,
    input  wire logic [9:0] want,
    input  wire logic [3:0] bounce_cyc,
    output logic      [9:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] held_q = '0;
    logic [9:0] prev_q = '0;
    logic [3:0] left_q = '0;
    initial pins = '0;
    // a bouncing contact flips between old and new level each cycle before it settles
    always @(posedge aclk) begin
        if (want !== held_q) begin
            prev_q <= held_q;
            held_q <= want;
            left_q <= bounce_cyc;
        end else if (left_q != 4'h0) begin
            left_q <= left_q - 4'h1;
            pins   <= left_q[0] ? held_q : prev_q;
        end else begin
            pins <= held_q;
        end
    end
endmodule // rcq_contact_model

// file: dv/rcq_core_tb_top.sv
/*
  self-checking bench of rcq_core: axi-lite master tasks and one task per scenario.
  assumes rcq_pkg compiled first; scan counts are shortened through parameters.
*/
`define RCQ_CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
end

module rcq_core_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rcq_pkg::*;
    localparam int FAST = 8;
    localparam int SLOW = 20;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = '0;
    logic [7:0]  s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        key_fwd = 1'b0, key_rev = 1'b0, remote_mode = 1'b0, drive_mode = 1'b0;
    logic [15:0] freq_ref = '0;
    logic [9:0]  want = '0;
    logic [9:0]  pins;
    logic [3:0]  bounce_cyc = '0;
    logic [7:0]  multi_q;
    rcq_drive_s  drive_cmd;
    int          miscompares = 0;
    int          samples_checked = 0;

    always #25 aclk = ~aclk;

    rcq_contact_model i_contacts (.aclk, .want, .bounce_cyc, .pins);

    rcq_core #(.MF_W(8), .FAST_CYC(FAST), .SLOW_CYC(SLOW)) i_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .terminal_fwd(pins[9]),
        .terminal_rev(pins[8]), .multi_in(pins[7:0]), .key_fwd, .key_rev, .remote_mode,
        .drive_mode, .freq_ref, .multi_q, .drive_cmd);

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_open;
        logic w_open;
        int   n;
        aw_open = 1'b1;
        w_open = 1'b1;
        r = 2'b11;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_bvalid === 1'b1 && !aw_open && !w_open) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
            if (aw_open && s_axi_awready === 1'b1) begin
                aw_open = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_open && s_axi_wready === 1'b1) begin
                w_open = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        if (n == 64) begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_open;
        int   n;
        ar_open = 1'b1;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_rvalid === 1'b1 && !ar_open) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
            if (ar_open && s_axi_arready === 1'b1) begin
                ar_open = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
        end
        if (n == 64) begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(8'h00, d, r);
        `RCQ_CHK(d, 32'h0000_0024)
        axi_rd(8'h04, d, r);
        `RCQ_CHK({r, d}, 34'h0_0000_0000)
        axi_rd(8'h0C, d, r);
        `RCQ_CHK(r, 2'b10)
        axi_wr(8'h0C, 32'hFFFF_FFFF, r);
        `RCQ_CHK(r, 2'b10)
        axi_wr(8'h08, 32'hFFFF_FFFF, r);
        `RCQ_CHK(r, 2'b10)
        $display("test regs done");
    endtask

    // both scan settings, reverse and multi-function inputs moved together
    task automatic t_scan();
        logic [1:0]  r;
        logic [31:0] d;
        int          cyc;
        int          n;
        for (int s = 0; s < 2; s++) begin
            cyc = s ? SLOW : FAST;
            axi_wr(8'h00, 32'h20 | (s << 2), r);
            tick(2 * SLOW);
            want <= {2'b01, 8'hA5};
            for (n = 0; n < 3 * cyc && multi_q !== 8'hA5; n++) tick(1);
            `RCQ_CHK(n >= cyc + 4 && n <= 2 * cyc + 3, 1'b1)
            axi_rd(8'h08, d, r);
            `RCQ_CHK(d[1:0], 2'b10)
            // a glitch of exactly one scan period is seen by exactly one scan
            want <= {2'b00, 8'h5A};
            tick(cyc);
            want <= {2'b01, 8'hA5};
            tick(3);
            `RCQ_CHK(multi_q, 8'hA5)
            tick(3 * cyc);
            `RCQ_CHK(multi_q, 8'hA5)
            want <= '0;
            tick(3 * cyc);
            `RCQ_CHK(multi_q, 8'h00)
        end
        $display("test scan done");
    endtask

    task automatic t_submin();
        logic [1:0]  r;
        logic [7:0]  ctl [6] = '{8'h20, 8'h21, 8'h22, 8'hA3, 8'h23, 8'h21};
        logic [15:0] fr [6] = '{16'h0032, 16'h0032, 16'h0032, 16'h0032, 16'h0032, 16'h0064};
        logic [15:0] ef [6] = '{16'h0032, 16'h0000, 16'h0064, 16'h0000, 16'h0032, 16'h0064};
        logic [1:0]  erc [6] = '{2'b10, 2'b01, 2'b10, 2'b10, 2'b10, 2'b10};
        drive_mode <= 1'b1;
        axi_wr(8'h04, 32'h0000_0064, r);
        key_fwd <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            freq_ref <= fr[i];
            axi_wr(8'h00, {24'h0, ctl[i]}, r);
            tick(3);
            `RCQ_CHK({drive_cmd.run_fwd, drive_cmd.coast_stop, drive_cmd.freq_cmd}, {erc[i], ef[i]})
        end
        key_fwd <= 1'b0;
        key_rev <= 1'b1;
        tick(3);
        `RCQ_CHK({drive_cmd.run_rev, drive_cmd.coast_stop}, 2'b10)
        freq_ref <= 16'h0032;
        tick(3);
        `RCQ_CHK({drive_cmd.run_rev, drive_cmd.coast_stop}, 2'b01)
        key_rev <= 1'b0;
        tick(3);
        $display("test submin done");
    endtask

    task automatic t_remote();
        logic [1:0] r;
        bounce_cyc <= 4'h5;
        for (int o = 0; o < 2; o++) begin
            axi_wr(8'h00, 32'h24 | (o << 3), r);
            want <= 10'h200;
            tick(3 * SLOW + 6);
            remote_mode <= 1'b1;
            tick(3);
            `RCQ_CHK(drive_cmd.run_fwd, o[0])
            if (o == 0) begin
                want <= 10'h000;
                tick(3 * SLOW + 6);
                want <= 10'h200;
                tick(3 * SLOW + 6);
                `RCQ_CHK(drive_cmd.run_fwd, 1'b1)
            end
            want <= 10'h000;
            remote_mode <= 1'b0;
            tick(3 * SLOW + 6);
        end
        bounce_cyc <= 4'h0;
        $display("test remote done");
    endtask

    task automatic t_nondrive();
        logic [1:0] r;
        logic [7:0] ctl [3] = '{8'h20, 8'h30, 8'h10};
        for (int i = 0; i < 3; i++) begin
            axi_wr(8'h00, {24'h0, ctl[i]}, r);
            drive_mode <= 1'b0;
            key_fwd <= 1'b1;
            tick(3);
            `RCQ_CHK(drive_cmd.run_fwd, i == 1)
            drive_mode <= 1'b1;
            tick(3);
            `RCQ_CHK(drive_cmd.run_fwd, i == 1)
            key_fwd <= 1'b0;
            tick(3);
            key_fwd <= 1'b1;
            tick(3);
            `RCQ_CHK(drive_cmd.run_fwd, 1'b1)
            key_fwd <= 1'b0;
            tick(3);
        end
        $display("test nondrive done");
    endtask

    initial begin
        tick(6);
        aresetn <= 1'b1;
        tick(1);
        t_regs();
        t_scan();
        t_submin();
        t_remote();
        t_nondrive();
        tally_and_finish();
    end
endmodule // rcq_core_tb_top
